//--- core/cpu_decode_map.svh
`ifndef CPU_DECODE_MAP_SVH
`define CPU_DECODE_MAP_SVH

// Opcode groups, selected by the upper opcode nibble.
`define GRP_BITBR   4'h0
`define GRP_BITOP   4'h1
`define GRP_REL     4'h2
`define RMW_DIR     4'h3
`define RMW_A       4'h4
`define RMW_X       4'h5
`define RMW_IX1     4'h6
`define RMW_IX      4'h7
`define RM_IMM      4'hA
`define RM_DIR      4'hB
`define RM_EXT      4'hC
`define RM_IX2      4'hD
`define RM_IX1      4'hE
`define RM_IX       4'hF

// Whole opcodes.
`define OP_MULTIPLY 8'h42
`define OP_STOP     8'h8E
`define OP_WAIT     8'h8F

// Read-modify-write operations, lower nibble.
`define RMW_NEG     4'h0
`define RMW_COM     4'h3
`define RMW_LSR     4'h4
`define RMW_ROR     4'h6
`define RMW_ASR     4'h7
`define RMW_LSL     4'h8
`define RMW_ROL     4'h9
`define RMW_DEC     4'hA
`define RMW_INC     4'hC
`define RMW_NZ_TEST 4'hD
`define RMW_CLR     4'hF

// Register/memory operations, lower nibble.
`define RM_CPX      4'h3
`define RM_STA      4'h7
`define RM_JUMP     4'hC
`define RM_SUB_JUMP 4'hD
`define RM_LDX      4'hE
`define RM_STX      4'hF

// Instruction lengths in bytes.
`define LEN_1       2'h1
`define LEN_2       2'h2
`define LEN_3       2'h3

// Highest address of the short indexed form and the page-zero high byte.
`define IX1_TOP     16'h01FE
`define PAGE_ZERO   8'h00

`endif

//--- core/cpu_decode_pkg.sv
package cpu_decode_pkg;

  typedef enum logic [2:0] {
    S_IDLE   = 3'b000,
    S_EXEC   = 3'b001,
    S_READ   = 3'b010,
    S_MODIFY = 3'b011,
    S_WRITE  = 3'b100,
    S_FINISH = 3'b101
  } seq_state_t;

endpackage

//--- core/branch_link_if.sv
`timescale 1ns/1ps
interface branch_link_if;
  logic [15:0] pc_next;
  logic [7:0]  rel;
  logic        take;
  logic [15:0] target;

  modport calc (input pc_next, input rel, input take, output target);
  modport user (output pc_next, output rel, output take, input target);
endinterface

//--- core/branch_target.sv
`timescale 1ns/1ps
module branch_target (
  branch_link_if.calc link
);
  wire [15:0] rel_ext;

  // Sign extension gives the reach of minus 128 to plus 127 from the next address.
  assign rel_ext     = {{8{link.rel[7]}}, link.rel};
  assign link.target = link.take ? 16'(link.pc_next + rel_ext) : link.pc_next;
endmodule

//--- core/cpu_decode.sv
// Contract
// - Long indexed mode is three bytes; address is index plus sixteen-bit offset.
// - First offset byte is the high half, second the low half.
// - Relative addressing only for branches; taken adds signed byte, else next.
// - Displacement is two's complement, reach -128 to +127 from next address.
// - Read-modify-write reads, alters, and writes back to the same place.
// - Single-bit set and clear exist only in direct addressing.
// - Negative-zero test reads and updates flags, never writes back.
// - Bit-test branch is opcode, direct address, displacement; opcode picks bit.
// - Bit-test branch copies the tested bit into carry, taken or not.
// - Bit set, clear and test reach any bit of the lowest 256 bytes.
// - Conditional branch only when met; jumps take no register operand.
// - Register/memory ops take accumulator or index, second operand from memory.
// - Branches on interrupt pin level, one for high and one for low.
// - Halt instruction stops oscillator and enables the interrupt pin.
// - Idle instruction stops the CPU clock and enables interrupts.
// - Multiply puts accumulator times index: high byte index, low accumulator.
// - Short indexed mode adds index and byte, reaching up to 01FE.
`timescale 1ns/1ps
`include "cpu_decode_map.svh"
module cpu_decode (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        instr_valid,
  output logic             instr_ready,
  input  wire logic [7:0]  opcode,
  input  wire logic [7:0]  oper_hi,
  input  wire logic [7:0]  oper_lo,
  input  wire logic [15:0] pc_in,
  input  wire logic [7:0]  acc_in,
  input  wire logic [7:0]  idx_in,
  input  wire logic        flag_c,
  input  wire logic        flag_z,
  input  wire logic        flag_n,
  input  wire logic        flag_h,
  input  wire logic        flag_i,
  input  wire logic        irq_pin,
  output logic [15:0]      mem_addr,
  output logic             mem_rd,
  output logic             mem_wr,
  output logic [7:0]       mem_wdata,
  input  wire logic [7:0]  mem_rdata,
  output logic             done,
  output logic [1:0]       instr_len,
  output logic [15:0]      next_pc,
  output logic             branch_taken,
  output logic [7:0]       acc_out,
  output logic [7:0]       idx_out,
  output logic             acc_load,
  output logic             idx_load,
  output logic [7:0]       reg_operand,
  output logic [7:0]       mem_operand,
  output logic             carry_load,
  output logic             carry_value,
  output logic             nz_load,
  output logic             neg_flag,
  output logic             zero_flag,
  output logic             stop_osc,
  output logic             stop_cpu_clk,
  output logic             irq_pin_enable,
  output logic             int_enable
);
  cpu_decode_pkg::seq_state_t state, next_state;
  logic [7:0]  op_q, b1_q, b2_q, a_q, x_q, opnd, rmw_res;
  logic [15:0] pc_q, ea_q;
  logic        c_q, z_q, n_q, h_q, i_q, irq_meta, irq_sync, rmw_c, rmw_cl;
  wire [3:0]  hi = op_q[7:4];
  wire [3:0]  lo = op_q[3:0];
  wire [2:0]  bitn = op_q[3:1];
  wire        is_bitbr = hi == `GRP_BITBR;
  wire        is_bitop = hi == `GRP_BITOP;
  wire        is_rel = hi == `GRP_REL;
  wire        rmw_mem = hi == `RMW_DIR || hi == `RMW_IX1 || hi == `RMW_IX;
  wire        is_rmw = rmw_mem || hi == `RMW_A || hi == `RMW_X;
  wire        is_nz_test = is_rmw && lo == `RMW_NZ_TEST;
  wire        is_rm = hi >= `RM_IMM;
  wire        is_jump = is_rm && hi != `RM_IMM && (lo == `RM_JUMP || lo == `RM_SUB_JUMP);
  wire        is_store = is_rm && hi != `RM_IMM && (lo == `RM_STA || lo == `RM_STX);
  wire        uses_x = lo == `RM_CPX || lo == `RM_LDX || lo == `RM_STX;
  wire        is_multiply = op_q == `OP_MULTIPLY;
  wire        is_stop = op_q == `OP_STOP;
  wire        is_wait = op_q == `OP_WAIT;
  wire        needs_read = is_bitbr || is_bitop || (is_rmw && rmw_mem)
                           || (is_rm && !is_jump && !is_store && hi != `RM_IMM);
  wire        writes = is_bitop || (rmw_mem && !is_nz_test) || is_store;
  wire        cap = (state == cpu_decode_pkg::S_EXEC && !needs_read)
                    || state == cpu_decode_pkg::S_MODIFY;
  wire [1:0]  len;
  wire [15:0] ea_dir, ea_ext, ea_ix2, ea_ix1, ea_ix, ea_next;
  wire [8:0]  ix1_sum;
  wire [7:0]  mask, bit_res;
  wire [7:0]  cond_set;
  wire [15:0] prod;
  wire        tbit, rel_take;
  // Direct forms, and with them single-bit set and clear, live in page zero.
  assign ea_dir  = {`PAGE_ZERO, b1_q};
  assign ea_ext  = {b1_q, b2_q};
  assign ea_ix2  = 16'({b1_q, b2_q} + {`PAGE_ZERO, x_q});
  assign ix1_sum = {1'b0, b1_q} + {1'b0, x_q};
  assign ea_ix1  = {7'h00, ix1_sum};
  assign ea_ix   = {`PAGE_ZERO, x_q};
  assign ea_next = hi == `RM_EXT ? ea_ext
                 : hi == `RM_IX2 ? ea_ix2
                 : (hi == `RM_IX1 || hi == `RMW_IX1) ? ea_ix1
                 : (hi == `RM_IX || hi == `RMW_IX) ? ea_ix
                 : ea_dir;
  assign len = (is_bitbr || hi == `RM_EXT || hi == `RM_IX2) ? `LEN_3
             : (is_bitop || is_rel || hi == `RMW_DIR || hi == `RMW_IX1
                || hi == `RM_IMM || hi == `RM_DIR || hi == `RM_IX1) ? `LEN_2
             : `LEN_1;
  assign mask    = 8'h01 << bitn;
  assign bit_res = op_q[0] ? (mem_rdata & ~mask) : (mem_rdata | mask);
  assign tbit    = mem_rdata[bitn];
  assign cond_set = {~irq_sync, ~i_q, ~n_q, ~h_q, ~z_q, ~c_q, ~(c_q | z_q), 1'b1};
  assign rel_take = cond_set[bitn] ^ op_q[0];
  assign prod = {8'h00, a_q} * {8'h00, x_q};
  branch_link_if bl ();
  assign bl.pc_next = 16'(pc_q + {14'h0000, len});
  assign bl.rel     = is_bitbr ? b2_q : b1_q;
  assign bl.take    = is_bitbr ? (tbit ^ op_q[0]) : (is_rel && rel_take);
  branch_target u_target (
    .link (bl)
  );
  always_comb
  begin
    opnd = rmw_mem ? mem_rdata : (hi == `RMW_A ? a_q : x_q);
    rmw_res = opnd;
    rmw_c = c_q;
    rmw_cl = 1'b1;
    case (lo)
      `RMW_NEG: begin rmw_res = 8'(8'h00 - opnd); rmw_c = opnd != 8'h00; end
      `RMW_COM: begin rmw_res = ~opnd; rmw_c = 1'b1; end
      `RMW_LSR: begin rmw_res = {1'b0, opnd[7:1]}; rmw_c = opnd[0]; end
      `RMW_ROR: begin rmw_res = {c_q, opnd[7:1]}; rmw_c = opnd[0]; end
      `RMW_ASR: begin rmw_res = {opnd[7], opnd[7:1]}; rmw_c = opnd[0]; end
      `RMW_LSL: begin rmw_res = {opnd[6:0], 1'b0}; rmw_c = opnd[7]; end
      `RMW_ROL: begin rmw_res = {opnd[6:0], c_q}; rmw_c = opnd[7]; end
      `RMW_DEC: begin rmw_res = 8'(opnd - 8'h01); rmw_cl = 1'b0; end
      `RMW_INC: begin rmw_res = 8'(opnd + 8'h01); rmw_cl = 1'b0; end
      `RMW_CLR: begin rmw_res = 8'h00; rmw_cl = 1'b0; end
      default:  rmw_cl = 1'b0;
    endcase
  end
  always_comb
  begin
    next_state = state;
    case (state)
      cpu_decode_pkg::S_IDLE:   if (instr_valid) next_state = cpu_decode_pkg::S_EXEC;
      cpu_decode_pkg::S_EXEC:   next_state = needs_read ? cpu_decode_pkg::S_READ
                                           : writes ? cpu_decode_pkg::S_WRITE
                                           : cpu_decode_pkg::S_FINISH;
      cpu_decode_pkg::S_READ:   next_state = cpu_decode_pkg::S_MODIFY;
      cpu_decode_pkg::S_MODIFY: next_state = writes ? cpu_decode_pkg::S_WRITE
                                           : cpu_decode_pkg::S_FINISH;
      cpu_decode_pkg::S_WRITE:  next_state = cpu_decode_pkg::S_FINISH;
      default:                  next_state = cpu_decode_pkg::S_IDLE;
    endcase
  end
  assign mem_addr    = ea_q;
  assign instr_ready = state == cpu_decode_pkg::S_IDLE;
  assign mem_rd      = state == cpu_decode_pkg::S_READ;
  assign mem_wr      = state == cpu_decode_pkg::S_WRITE;
  assign done        = state == cpu_decode_pkg::S_FINISH;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state    <= cpu_decode_pkg::S_IDLE;
      irq_meta <= 1'b1;
      irq_sync <= 1'b1;
    end
    else
    begin
      state    <= next_state;
      irq_meta <= irq_pin;
      irq_sync <= irq_meta;
    end
  end
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      {op_q, b1_q, b2_q, a_q, x_q, pc_q} <= '0;
      {c_q, z_q, n_q, h_q, i_q} <= '0;
      ea_q <= '0;
    end
    else if (instr_valid && instr_ready)
    begin
      {op_q, b1_q, b2_q, a_q, x_q, pc_q} <= {opcode, oper_hi, oper_lo, acc_in, idx_in, pc_in};
      {c_q, z_q, n_q, h_q, i_q} <= {flag_c, flag_z, flag_n, flag_h, flag_i};
    end
    else if (state == cpu_decode_pkg::S_EXEC)
      ea_q <= ea_next;
  end
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      {instr_len, next_pc, branch_taken, acc_out, idx_out, acc_load, idx_load} <= '0;
      {reg_operand, mem_operand, carry_load, carry_value, nz_load, neg_flag} <= '0;
      {zero_flag, stop_osc, stop_cpu_clk, irq_pin_enable, int_enable, mem_wdata} <= '0;
    end
    else if (cap)
    begin
      instr_len    <= len;
      next_pc      <= is_jump ? ea_next : bl.target;
      branch_taken <= bl.take;
      acc_out      <= is_multiply ? prod[7:0] : rmw_res;
      idx_out      <= is_multiply ? prod[15:8] : rmw_res;
      acc_load     <= is_multiply || (hi == `RMW_A && !is_nz_test);
      idx_load     <= is_multiply || (hi == `RMW_X && !is_nz_test);
      reg_operand  <= uses_x ? x_q : a_q;
      mem_operand  <= mem_rdata;
      carry_load   <= is_bitbr || (is_rmw && rmw_cl);
      carry_value  <= is_bitbr ? tbit : rmw_c;
      nz_load      <= is_rmw;
      neg_flag     <= rmw_res[7];
      zero_flag    <= rmw_res == 8'h00;
      stop_osc       <= is_stop;
      irq_pin_enable <= is_stop;
      stop_cpu_clk <= is_wait;
      int_enable   <= is_wait;
      mem_wdata    <= is_store ? (uses_x ? x_q : a_q) : is_bitop ? bit_res : rmw_res;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_ix2_ea;
    state == cpu_decode_pkg::S_EXEC && is_rm && hi == `RM_IX2
      |=> ea_q == 16'({$past(b1_q), $past(b2_q)} + {8'h00, $past(x_q)});
  endproperty
  a_ix2_ea: assert property (p_ix2_ea) else $error("long indexed address wrong");
  property p_ix1_range;
    state == cpu_decode_pkg::S_READ && (hi == `RM_IX1 || hi == `RMW_IX1)
      |-> ea_q <= `IX1_TOP && ea_q == {8'h00, b1_q} + {8'h00, x_q};
  endproperty
  a_ix1_range: assert property (p_ix1_range) else $error("short indexed address wrong");
  property p_rel_branch;
    state == cpu_decode_pkg::S_EXEC && is_rel |-> ##1 done && next_pc == (branch_taken
            ? 16'(pc_q + 16'h0002 + {{8{b1_q[7]}}, b1_q}) : 16'(pc_q + 16'h0002));
  endproperty
  a_rel_branch: assert property (p_rel_branch) else $error("relative target wrong");
  property p_rmw_writeback;
    state == cpu_decode_pkg::S_READ && rmw_mem && !is_nz_test
      |-> ##2 mem_wr && mem_addr == $past(mem_addr, 2);
  endproperty
  a_rmw_writeback: assert property (p_rmw_writeback) else $error("no write-back");
  property p_nz_test_nowrite;
    state == cpu_decode_pkg::S_READ && is_nz_test |-> ##1 !mem_wr ##1 (!mem_wr && done);
  endproperty
  a_nz_test_nowrite: assert property (p_nz_test_nowrite) else $error("test wrote memory");
  property p_bit_carry;
    state == cpu_decode_pkg::S_MODIFY && is_bitbr
      |=> carry_load && carry_value == $past(mem_rdata[bitn]) && instr_len == `LEN_3;
  endproperty
  a_bit_carry: assert property (p_bit_carry) else $error("tested bit not in carry");
  property p_bitop_page0;
    mem_wr && is_bitop |-> mem_addr[15:8] == 8'h00;
  endproperty
  a_bitop_page0: assert property (p_bitop_page0) else $error("bit op left page zero");
  property p_irq_branch;
    state == cpu_decode_pkg::S_EXEC && is_rel && bitn == 3'h7
      |=> branch_taken == ($past(irq_sync) ^ ~$past(op_q[0]));
  endproperty
  a_irq_branch: assert property (p_irq_branch) else $error("pin branch wrong");
  property p_multiply;
    state == cpu_decode_pkg::S_EXEC && is_multiply
      |=> acc_load && idx_load && {idx_out, acc_out} == $past(a_q) * $past(x_q);
  endproperty
  a_multiply: assert property (p_multiply) else $error("multiply result wrong");
  property p_stop_wait;
    done && (is_stop || is_wait)
      |-> stop_osc == is_stop && irq_pin_enable == is_stop && stop_cpu_clk == is_wait;
  endproperty
  a_stop_wait: assert property (p_stop_wait) else $error("low power controls wrong");
  c_bitbr:    cover property (done && is_bitbr && branch_taken);
  c_store:    cover property (mem_wr && is_store);
  c_rmw:      cover property (mem_wr && rmw_mem);
  c_multiply: cover property (done && is_multiply);
endmodule

//--- dv/mem_model.sv
`timescale 1ns/1ps
module mem_model (
  input  wire logic        clk,
  input  wire logic [15:0] mem_addr,
  input  wire logic        mem_rd,
  input  wire logic        mem_wr,
  input  wire logic [7:0]  mem_wdata,
  output logic [7:0]       mem_rdata
);
  logic [7:0] mem [0:65535];

  initial mem_rdata = 8'h00;

  // Read data is valid for one cycle only; otherwise the bus shows changing garbage.
  always @(posedge clk)
  begin
    if (mem_rd)
      mem_rdata <= mem[mem_addr];
    else
      mem_rdata <= ~mem_rdata;
    if (mem_wr)
      mem[mem_addr] <= mem_wdata;
  end
endmodule

//--- dv/testbench.sv
`timescale 1ns/1ps
`define CHK(g, e, s) begin check_count++; if ((g) !== (e)) begin fail_count++; \
  $display("Error t=%0t %s got %0h exp %0h", $time, s, g, e); end end
module testbench;
  logic        clk, arst_n, instr_valid, instr_ready, flag_c, flag_z, flag_n, flag_h;
  logic        flag_i, irq_pin, mem_rd, mem_wr, done, branch_taken, acc_load, idx_load;
  logic        carry_load, carry_value, nz_load, neg_flag, zero_flag, stop_osc;
  logic        stop_cpu_clk, irq_pin_enable, int_enable, saw_wr, b;
  logic [1:0]  instr_len;
  logic [7:0]  opcode, oper_hi, oper_lo, acc_in, idx_in, mem_wdata, mem_rdata, acc_out;
  logic [7:0]  idx_out, reg_operand, mem_operand, d, r, hb, lb, op;
  logic [15:0] pc_in, mem_addr, next_pc, ea;
  int          fail_count, check_count, cycles, n, rd_n;

  cpu_decode cpu_decode_i (.*);
  mem_model mem_model_i (.*);

  initial
  begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end

  task automatic summarize;
    $display("Checks %0d errors %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      summarize();
    end
  end

  task automatic rnd;
    pc_in = 16'($urandom());
    acc_in = 8'($urandom());
    idx_in = 8'($urandom());
    hb = 8'($urandom());
    lb = 8'($urandom());
    d = 8'($urandom());
    {flag_c, flag_z, flag_n, flag_h, flag_i} = 5'($urandom());
  endtask

  // Issues one instruction and counts falling edges until done.
  task automatic run(input logic [7:0] o, input logic [7:0] h, input logic [7:0] l,
                     input int lat);
    @(negedge clk);
    while (instr_ready !== 1'h1)
      @(negedge clk);
    opcode = o;
    oper_hi = h;
    oper_lo = l;
    instr_valid = 1'h1;
    @(negedge clk);
    instr_valid = 1'h0;
    n = 1;
    rd_n = 0;
    saw_wr = 1'h0;
    while (done !== 1'h1 && n < 20)
    begin
      saw_wr |= (mem_wr === 1'h1);
      rd_n += (mem_rd === 1'h1);
      @(negedge clk);
      n++;
    end
    `CHK(n, lat, "latency")
    `CHK(rd_n, lat >= 4, "read pulses")
  endtask

  function automatic logic [15:0] sx(input logic [7:0] v);
    return {{8{v[7]}}, v};
  endfunction

  function automatic logic cond(input logic [7:0] o);
    logic c;
    case (o[3:1])
      3'h0: c = 1'h1;
      3'h1: c = !(flag_c | flag_z);
      3'h2: c = !flag_c;
      3'h3: c = !flag_z;
      3'h4: c = !flag_h;
      3'h5: c = !flag_n;
      3'h6: c = !flag_i;
      default: c = !irq_pin;
    endcase
    return c ^ o[0];
  endfunction

  initial
  begin
    void'($urandom(67670));
    arst_n = 1'h0;
    instr_valid = 1'h0;
    opcode = 8'h00;
    oper_hi = 8'h00;
    oper_lo = 8'h00;
    irq_pin = 1'h1;
    rnd();
    repeat (6) @(posedge clk);
    @(negedge clk);
    arst_n = 1'h1;
    for (int i = 0; i < 20; i++)
    begin
      rnd();
      if (i == 0)
        {idx_in, hb, lb} = 24'hFFFFFF;
      ea = idx_in + {hb, lb};
      mem_model_i.mem[ea] = d;
      op = i[0] ? 8'hD3 : 8'hD6;
      run(op, hb, lb, 4);
      `CHK(mem_addr, ea, "ix2 addr")
      `CHK(instr_len, 2'h3, "ix2 len")
      `CHK(mem_operand, d, "mem opnd")
      `CHK(reg_operand, op[0] ? idx_in : acc_in, "reg opnd")
    end
    rnd();
    idx_in = 8'hFF;
    mem_model_i.mem[16'h01FE] = d;
    run(8'hE6, 8'hFF, 8'h00, 4);
    `CHK(mem_addr, 16'h01FE, "ix1 addr")
    `CHK(mem_operand, d, "ix1 opnd")
    for (int i = 0; i < 32; i++)
    begin
      rnd();
      irq_pin = 1'($urandom());
      repeat (3) @(negedge clk);
      op = {4'h2, i[3:0]};
      r = (i == 0) ? 8'h80 : (i == 16) ? 8'h7F : d;
      b = cond(op);
      run(op, r, 8'h00, 2);
      `CHK(branch_taken, b, "br taken")
      `CHK(next_pc, b ? pc_in + 16'h0002 + sx(r) : pc_in + 16'h0002, "br pc")
    end
    for (int i = 0; i < 32; i++)
    begin
      rnd();
      op = {4'h0, i[3:0]};
      mem_model_i.mem[{8'h00, hb}] = d;
      b = d[op[3:1]];
      run(op, hb, lb, 4);
      `CHK(mem_addr, {8'h00, hb}, "bb addr")
      `CHK(instr_len, 2'h3, "bb len")
      `CHK(carry_value, b, "bb carry")
      `CHK(carry_load, 1'h1, "bb cload")
      `CHK(branch_taken, b ^ op[0], "bb taken")
      ea = pc_in + 16'h0003;
      `CHK(next_pc, (b ^ op[0]) ? ea + sx(lb) : ea, "bb pc")
    end
    for (int i = 0; i < 16; i++)
    begin
      rnd();
      op = {4'h1, i[3:0]};
      mem_model_i.mem[{8'h00, hb}] = d;
      r = op[0] ? d & ~(8'h01 << op[3:1]) : d | (8'h01 << op[3:1]);
      run(op, hb, 8'h00, 5);
      `CHK(mem_model_i.mem[{8'h00, hb}], r, "bit op")
    end
    for (int i = 0; i < 4; i++)
    begin
      rnd();
      if (i < 2)
        d = 8'h00;
      op = i[0] ? 8'h3D : 8'h3C;
      mem_model_i.mem[{8'h00, hb}] = d;
      run(op, hb, 8'h00, i[0] ? 4 : 5);
      r = i[0] ? d : 8'(d + 8'h01);
      `CHK(mem_model_i.mem[{8'h00, hb}], r, "rmw mem")
      `CHK(saw_wr, !i[0], "rmw write")
      if (i[0])
      begin
        `CHK(nz_load, 1'h1, "test load")
        `CHK(neg_flag, d[7], "test neg")
        `CHK(zero_flag, d == 8'h00, "test zero")
      end
    end
    rnd();
    ea = acc_in * idx_in;
    run(8'h42, 8'h00, 8'h00, 2);
    `CHK({idx_out, acc_out}, ea, "multiply")
    `CHK({idx_load, acc_load}, 2'h3, "multiply load")
    for (int i = 0; i < 2; i++)
    begin
      rnd();
      ea = (i == 1 ? idx_in : 8'h00) + {hb, lb};
      run(i == 1 ? 8'hDC : 8'hCC, hb, lb, 2);
      `CHK(next_pc, ea, "jump pc")
    end
    for (int i = 0; i < 2; i++)
    begin
      rnd();
      run(i[0] ? 8'hBF : 8'hB7, hb, 8'h00, 3);
      `CHK(mem_model_i.mem[{8'h00, hb}], i[0] ? idx_in : acc_in, "store")
      run(i[0] ? 8'h5C : 8'h4C, 8'h00, 8'h00, 2);
      r = i[0] ? idx_in : acc_in;
      `CHK(i[0] ? idx_out : acc_out, 8'(r + 8'h01), "reg inc")
      `CHK({idx_load, acc_load}, i[0] ? 2'h2 : 2'h1, "reg load")
    end
    run(8'h8F, 8'h00, 8'h00, 2);
    `CHK({stop_cpu_clk, int_enable, stop_osc}, 3'h6, "idle")
    run(8'h8E, 8'h00, 8'h00, 2);
    `CHK({stop_osc, irq_pin_enable}, 2'h3, "halt")
    summarize();
  end
endmodule
